// ==== core/dmac_pkg.sv ====
// Constants and types for the five-channel DMA arm and trigger control block
package dmac_pkg;
  localparam int NUM_CH = 5;
  localparam logic [7:0] ARM_ADDR = 8'hd6;
  localparam logic [7:0] REQ_ADDR = 8'hd7;
  localparam logic [7:0] FLAG_ADDR = 8'hd1;
  localparam int ABORT_BIT = 7;
  localparam logic [4:0] CH_MASK = 5'h1f;
  localparam logic [7:0] SFR_RESET = 8'h00;
  localparam logic [1:0] PRIO_LOW = 2'h0;
  localparam logic [1:0] PRIO_NORMAL = 2'h1;
  localparam logic [1:0] PRIO_HIGH = 2'h2;
  localparam logic [2:0] VARIABLE_LENGTH_MODE_FIXED = 3'h0;
  localparam logic [2:0] VARIABLE_LENGTH_MODE_RSVD = 3'h7;
  localparam logic [4:0] TRIGGER_SELECT_NONE = 5'h00;
  localparam logic [4:0] TRIGGER_SELECT_PREV = 5'h01;
  localparam logic [7:0] LEN7_MASK = 8'h7f;
  // Bus activity tracker state, one tracker shared by all channels
  typedef enum logic [1:0] {
    DMAC_IDLE = 2'b00,
    DMAC_BUSY = 2'b01,
    DMAC_DONE = 2'b11
  } dmac_state_t;
endpackage : dmac_pkg

// ==== core/dmac_len_reg.sv ====
// Per-channel captured length registers with registered read data
`timescale 1ns/1ps
`default_nettype none
module dmac_len_reg (
  input wire logic ref_clk_in, // System clock
  input wire logic reset_n_in, // Async reset, active low
  input wire logic wr_en_in, // Write strobe
  input wire logic [2:0] wr_ch_in, // Channel written
  input wire logic [7:0] wr_data_in, // Length value
  input wire logic [2:0] rd_ch_in, // Channel read
  output logic [7:0] rd_data_out // Registered read data
);
  logic [7:0] mem_r [dmac_pkg::NUM_CH];

  genvar g;
  generate
    for (g = 0; g < dmac_pkg::NUM_CH; g++) begin : g_ent
      always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          mem_r[g] <= 8'h00;
        end else if (wr_en_in && (wr_ch_in == 3'(g))) begin
          mem_r[g] <= wr_data_in;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_data_out <= 8'h00;
    end else if (rd_ch_in < 3'(dmac_pkg::NUM_CH)) begin
      rd_data_out <= mem_r[rd_ch_in];
    end else begin
      rd_data_out <= 8'h00;
    end
  end
endmodule : dmac_len_reg
`default_nettype wire

// ==== core/dmac_ctrl.sv ====
// Arm, abort, manual trigger, arbitration and done-flag control for five DMA channels
`timescale 1ns/1ps
`default_nettype none
module dmac_ctrl (
  input wire logic ref_clk_in, // System clock, 100 MHz
  input wire logic reset_n_in, // Async reset, active low
  input wire logic sfr_wr_in, // SFR write strobe
  input wire logic sfr_rd_in, // SFR read strobe
  input wire logic [7:0] sfr_addr_in, // SFR address
  input wire logic [7:0] sfr_wdata_in, // SFR write data
  output logic [7:0] sfr_rdata_out, // SFR read data, registered
  input wire logic [4:0] channel_irq_enable_in, // Per-channel interrupt enable
  input wire logic [4:0] length_seven_bit_select_in, // Per-channel 7-bit length select
  input wire logic [9:0] priority_in, // Two priority bits per channel
  input wire logic [14:0] variable_length_mode_in, // Three bits per channel
  input wire logic [4:0] transfer_word_size_in, // Per-channel word transfers
  input wire logic [4:0] repeat_mode_in, // Per-channel repeated mode
  input wire logic [24:0] trigger_select_in, // Five bits per channel
  input wire logic [4:0] periph_trigger_in, // Per-channel selected peripheral trigger pulse
  input wire logic cpu_mem_req_in, // CPU competes for memory this cycle
  input wire logic [4:0] count_reached_in, // Engine reports count reached, pulse
  input wire logic [2:0] len_ch_in, // Channel whose first source byte arrives
  input wire logic len_load_in, // First source byte valid, pulse
  input wire logic [7:0] len_byte_in, // First source byte
  output logic [4:0] channel_arm_bit_out, // Arm bits
  output logic [4:0] grant_out, // One-hot memory grant, pulse
  output logic cpu_stall_out, // CPU held off this cycle
  output logic [4:0] abort_out, // Abort pulse per channel
  output logic [4:0] irq_req_out, // Interrupt request pulse per channel
  output logic [4:0] channel_done_flag_out, // Sticky done flags
  output logic [7:0] len_rdata_out // Captured length of channel len_ch_in
);
  logic [4:0] arm_r;
  logic [4:0] req_r;
  logic [4:0] pend_r;
  logic [4:0] flag_r;
  logic [4:0] grant_r;
  logic [4:0] fair_r;
  logic stall_r;
  logic [4:0] abort_r;
  logic [4:0] irq_r;
  logic [7:0] rdata_r;
  logic [4:0] grant_nxt;
  logic stall_nxt;
  logic [4:0] trigger_select_ev;
  logic [4:0] want;
  logic [4:0] abort_sel;
  logic [4:0] done_ev;
  logic arm_wr;
  logic req_wr;
  logic flag_wr;
  logic [7:0] len_val;
  dmac_pkg::dmac_state_t st_r;
  dmac_pkg::dmac_state_t st_nxt;

  assign arm_wr = sfr_wr_in && (sfr_addr_in == dmac_pkg::ARM_ADDR);
  assign req_wr = sfr_wr_in && (sfr_addr_in == dmac_pkg::REQ_ADDR);
  assign flag_wr = sfr_wr_in && (sfr_addr_in == dmac_pkg::FLAG_ADDR);
  assign abort_sel = (arm_wr && sfr_wdata_in[dmac_pkg::ABORT_BIT]) ?
                     (sfr_wdata_in[4:0] & dmac_pkg::CH_MASK) : 5'h00;
  assign done_ev = count_reached_in & arm_r & ~abort_sel;

  // ****************************************************************
  // Trigger sources
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < dmac_pkg::NUM_CH; g++) begin : g_trigger_select
      logic [4:0] sel;
      assign sel = trigger_select_in[g*5 +: 5];
      if (g == 0) begin : g_first
        assign trigger_select_ev[g] = (sel == dmac_pkg::TRIGGER_SELECT_NONE) ? 1'b0 :
                            (sel == dmac_pkg::TRIGGER_SELECT_PREV) ? 1'b0 : periph_trigger_in[g];
      end else begin : g_rest
        assign trigger_select_ev[g] = (sel == dmac_pkg::TRIGGER_SELECT_NONE) ? 1'b0 :
                            (sel == dmac_pkg::TRIGGER_SELECT_PREV) ? done_ev[g-1] :
                            periph_trigger_in[g];
      end
    end
  endgenerate

  // Pending triggers plus manual requests; only armed channels compete
  assign want = (pend_r | req_r) & arm_r & ~abort_sel;

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  // Lowest channel number wins among channels; CPU contest decided per priority
  always_comb begin
    grant_nxt = 5'h00;
    stall_nxt = 1'b0;
    for (int i = dmac_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (want[i]) begin
        grant_nxt = 5'h00;
        grant_nxt[i] = 1'b1;
      end
    end
    for (int i = 0; i < dmac_pkg::NUM_CH; i++) begin
      if (grant_nxt[i] && cpu_mem_req_in) begin
        unique case (priority_in[i*2 +: 2])
          dmac_pkg::PRIO_LOW: grant_nxt[i] = 1'b0;
          dmac_pkg::PRIO_NORMAL: begin
            if (!fair_r[i]) begin
              grant_nxt[i] = 1'b0;
            end else begin
              stall_nxt = 1'b1;
            end
          end
          dmac_pkg::PRIO_HIGH: stall_nxt = 1'b1;
          default: grant_nxt[i] = 1'b0; // Reserved code behaves as low
        endcase
      end
    end
  end

  // Fairness toggle: after losing once to the CPU, the next contest goes to DMA
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fair_r <= 5'h00;
    end else begin
      for (int i = 0; i < dmac_pkg::NUM_CH; i++) begin
        if (want[i] && cpu_mem_req_in && priority_in[i*2 +: 2] == dmac_pkg::PRIO_NORMAL) begin
          fair_r[i] <= ~grant_nxt[i];
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      grant_r <= 5'h00;
      stall_r <= 1'b0;
    end else begin
      grant_r <= grant_nxt;
      stall_r <= stall_nxt;
    end
  end

  // ****************************************************************
  // Pending hardware triggers
  // ****************************************************************
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pend_r <= 5'h00;
    end else begin
      pend_r <= ((pend_r & ~grant_nxt) | trigger_select_ev) & ~abort_sel;
    end
  end

  // ****************************************************************
  // Arm register
  // ****************************************************************
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      arm_r <= 5'h00;
    end else if (|abort_sel) begin
      arm_r <= arm_r & ~abort_sel;
    end else if (arm_wr) begin
      arm_r <= sfr_wdata_in[4:0] & dmac_pkg::CH_MASK;
    end else begin
      arm_r <= arm_r & ~(done_ev & ~repeat_mode_in);
    end
  end

  // ****************************************************************
  // Manual trigger register
  // ****************************************************************
  // Grant clear beats a simultaneous set of the same bit: the grant consumes it
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      req_r <= 5'h00;
    end else begin
      req_r <= ((req_r | (req_wr ? sfr_wdata_in[4:0] : 5'h00))
                & ~grant_nxt & ~abort_sel);
    end
  end

  // ****************************************************************
  // Done flags and interrupt requests
  // ****************************************************************
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flag_r <= 5'h00;
    end else begin
      flag_r <= ((flag_wr ? (flag_r & sfr_wdata_in[4:0]) : flag_r) | done_ev);
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_r <= 5'h00;
      abort_r <= 5'h00;
    end else begin
      irq_r <= done_ev & channel_irq_enable_in;
      abort_r <= abort_sel;
    end
  end

  // ****************************************************************
  // Variable length capture
  // ****************************************************************
  always_comb begin
    len_val = len_byte_in;
    if (len_ch_in < 3'(dmac_pkg::NUM_CH)) begin
      if (variable_length_mode_in[len_ch_in*3 +: 3] != dmac_pkg::VARIABLE_LENGTH_MODE_FIXED &&
          variable_length_mode_in[len_ch_in*3 +: 3] != dmac_pkg::VARIABLE_LENGTH_MODE_RSVD &&
          !transfer_word_size_in[len_ch_in] && length_seven_bit_select_in[len_ch_in]) begin
        len_val = len_byte_in & dmac_pkg::LEN7_MASK;
      end
    end
  end

  dmac_len_reg u_len (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .wr_en_in(len_load_in),
    .wr_ch_in(len_ch_in),
    .wr_data_in(len_val),
    .rd_ch_in(len_ch_in),
    .rd_data_out(len_rdata_out)
  );

  // ****************************************************************
  // Bus activity tracker
  // ****************************************************************
  always_comb begin
    unique case (st_r)
      dmac_pkg::DMAC_IDLE: st_nxt = (|grant_nxt) ? dmac_pkg::DMAC_BUSY : dmac_pkg::DMAC_IDLE;
      dmac_pkg::DMAC_BUSY: st_nxt = (|done_ev) ? dmac_pkg::DMAC_DONE :
                                    (|grant_nxt) ? dmac_pkg::DMAC_BUSY : dmac_pkg::DMAC_IDLE;
      dmac_pkg::DMAC_DONE: st_nxt = dmac_pkg::DMAC_IDLE;
      default: st_nxt = dmac_pkg::DMAC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r <= dmac_pkg::DMAC_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Register read
  // ****************************************************************
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_r <= dmac_pkg::SFR_RESET;
    end else if (sfr_rd_in) begin
      unique case (sfr_addr_in)
        dmac_pkg::ARM_ADDR: rdata_r <= {3'h0, arm_r};
        dmac_pkg::REQ_ADDR: rdata_r <= {3'h0, req_r};
        dmac_pkg::FLAG_ADDR: rdata_r <= {3'h0, flag_r};
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  assign sfr_rdata_out = rdata_r;
  assign channel_arm_bit_out = arm_r;
  assign grant_out = grant_r;
  assign cpu_stall_out = stall_r;
  assign abort_out = abort_r;
  assign irq_req_out = irq_r;
  assign channel_done_flag_out = flag_r;
endmodule : dmac_ctrl
`default_nettype wire

// ==== sim/dmac_ctrl_monitor.sv ====
// Checker for the DMA arm, done-flag and arbitration ports
`timescale 1ns/1ps
`default_nettype none
module dmac_ctrl_monitor (
  input wire logic ref_clk_in, // Clock
  input wire logic reset_n_in, // Reset
  input wire logic sfr_wr_in, // Write
  input wire logic sfr_rd_in, // Read
  input wire logic [7:0] sfr_addr_in, // Address
  input wire logic [7:0] sfr_wdata_in, // Write data
  input wire logic [7:0] sfr_rdata_out, // Read data
  input wire logic [4:0] channel_irq_enable_in, // Irq enables
  input wire logic [9:0] priority_in, // Priorities
  input wire logic [4:0] repeat_mode_in, // Repeat modes
  input wire logic cpu_mem_req_in, // CPU request
  input wire logic [4:0] count_reached_in, // Count pulses
  input wire logic [4:0] channel_arm_bit_out, // Arm bits
  input wire logic [4:0] grant_out, // Grants
  input wire logic cpu_stall_out, // CPU stall
  input wire logic [4:0] irq_req_out, // Irq pulses
  input wire logic [4:0] channel_done_flag_out // Done flags
);
  // ********
  // Checks
  // ********
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_grant_one_hot: assert property ($onehot0(grant_out))
    else $error("grant not one-hot");
  a_grant_when_armed: assert property ((grant_out & ~$past(channel_arm_bit_out)) == 5'h00)
    else $error("grant to unarmed channel");
  a_low_prio_defers: assert property ($past(cpu_mem_req_in) && $past(priority_in[1:0]) == 2'h0
    |-> !grant_out[0]) else $error("low priority beat cpu");
  a_stall_means_win: assert property (cpu_stall_out |-> |grant_out)
    else $error("stall without grant");
  a_irq_has_cause: assert property ((irq_req_out & ~($past(count_reached_in)
    & $past(channel_irq_enable_in) & $past(channel_arm_bit_out))) == 5'h00)
    else $error("irq without cause");
  a_irq_sets_flag: assert property ((irq_req_out & ~channel_done_flag_out) == 5'h00)
    else $error("irq without flag");
  a_arm_read_back: assert property ($past(sfr_rd_in && sfr_addr_in == dmac_pkg::ARM_ADDR)
    |-> sfr_rdata_out == {3'h0, $past(channel_arm_bit_out)})
    else $error("arm read mismatch");
  a_abort_disarms: assert property ($past(sfr_wr_in && sfr_addr_in == dmac_pkg::ARM_ADDR
    && sfr_wdata_in[7]) |-> (channel_arm_bit_out & $past(sfr_wdata_in[4:0])) == 5'h00)
    else $error("abort left channel armed");
  a_count_disarms: assert property ($past(count_reached_in[0] && channel_arm_bit_out[0]
    && !repeat_mode_in[0] && !sfr_wr_in) |-> !channel_arm_bit_out[0])
    else $error("single mode stayed armed");
  a_flag_sticky: assert property (|($past(channel_done_flag_out) & ~channel_done_flag_out)
    |-> $past(sfr_wr_in && sfr_addr_in == dmac_pkg::FLAG_ADDR))
    else $error("flag dropped by itself");
  c_dma_beats_cpu: cover property (cpu_stall_out);
  c_irq_raised: cover property (|irq_req_out);
  c_abort_write: cover property (sfr_wr_in && sfr_addr_in == dmac_pkg::ARM_ADDR && sfr_wdata_in[7]);
endmodule : dmac_ctrl_monitor
`default_nettype wire

// ==== sim/dmac_cpu_model.sv ====
// Behavioural CPU competing with the DMA for memory
`timescale 1ns/1ps
`default_nettype none
module dmac_cpu_model (
  input wire logic ref_clk_in, // System clock
  input wire logic reset_n_in, // Reset, active low
  input wire logic [1:0] mode_in, // 0 idle, 1 always, 2 random
  output logic cpu_mem_req_out // Memory request
);
  // Steady contention is the harshest case for the alternating arbiter
  always @(negedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) cpu_mem_req_out <= 1'b0;
    else cpu_mem_req_out <= (mode_in == 2'h1) || (mode_in == 2'h2 && $urandom_range(1) == 1);
  end
endmodule : dmac_cpu_model
`default_nettype wire

// ==== sim/dmac_ctrl_tb_top.sv ====
// Self-checking testbench for the DMA arm and trigger control block
`timescale 1ns/1ps
`default_nettype none
module dmac_ctrl_tb_top;
  logic ref_clk_in = 1'b0, reset_n_in = 1'b0, sfr_wr_in = 1'b0, sfr_rd_in = 1'b0;
  logic cpu_mem_req_in, cpu_stall_out, len_load_in = 1'b0, st;
  logic [7:0] sfr_addr_in = '0, sfr_wdata_in = '0, sfr_rdata_out, len_byte_in = '0, len_rdata_out;
  logic [4:0] channel_irq_enable_in = '0, length_seven_bit_select_in = '0;
  logic [4:0] transfer_word_size_in = '0, repeat_mode_in = '0, periph_trigger_in = '0;
  logic [4:0] count_reached_in = '0, channel_arm_bit_out, grant_out, abort_out;
  logic [4:0] irq_req_out, channel_done_flag_out;
  logic [9:0] priority_in = '0;
  logic [14:0] variable_length_mode_in = '0;
  logic [24:0] trigger_select_in = '0;
  logic [2:0] len_ch_in = '0;
  logic [1:0] cpu_mode = 2'h0;
  logic [7:0] regs [4] = '{dmac_pkg::ARM_ADDR, dmac_pkg::REQ_ADDR, dmac_pkg::FLAG_ADDR, 8'hd0};
  int miscompares = 0, samples_checked = 0, arm_m = 0, flag_m = 0, n, en, rep;
  // ********
  // Harness
  // ********
  initial forever #5 ref_clk_in = ~ref_clk_in;
  dmac_ctrl dut (.ref_clk_in, .reset_n_in, .sfr_wr_in, .sfr_rd_in, .sfr_addr_in, .sfr_wdata_in,
    .sfr_rdata_out, .channel_irq_enable_in, .length_seven_bit_select_in, .priority_in,
    .variable_length_mode_in, .transfer_word_size_in, .repeat_mode_in, .trigger_select_in,
    .periph_trigger_in, .cpu_mem_req_in, .count_reached_in, .len_ch_in, .len_load_in,
    .len_byte_in, .channel_arm_bit_out, .grant_out, .cpu_stall_out, .abort_out, .irq_req_out,
    .channel_done_flag_out, .len_rdata_out);
  dmac_cpu_model u_cpu (.ref_clk_in, .reset_n_in, .mode_in(cpu_mode),
    .cpu_mem_req_out(cpu_mem_req_in));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    sfr_wr_in = 1'b1;
    sfr_addr_in = a;
    sfr_wdata_in = d;
    @(negedge ref_clk_in);
    sfr_wr_in = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk_in);
    sfr_rd_in = 1'b1;
    sfr_addr_in = a;
    @(negedge ref_clk_in);
    sfr_rd_in = 1'b0;
    chk(sfr_rdata_out, exp);
  endtask : rd
  // Grant is a one-cycle pulse, so every cycle of the window is looked at
  task automatic wait_grant(input int ch, input int lim);
    n = -1;
    st = 1'b0;
    for (int i = 0; i < lim; i++) begin
      if (n < 0 && grant_out[ch] === 1'b1) begin
        n = i;
        st = cpu_stall_out;
      end
      @(negedge ref_clk_in);
    end
  endtask : wait_grant
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    #100000;
    miscompares++;
    test_done();
  end
  // ********
  // Scenarios
  // ********
  initial begin
    void'($urandom(56));
    repeat (4) @(posedge ref_clk_in);
    @(negedge ref_clk_in) reset_n_in = 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    wr(dmac_pkg::ARM_ADDR, 8'h7f);
    rd(dmac_pkg::ARM_ADDR, 8'h1f);
    wr(dmac_pkg::ARM_ADDR, 8'h85);
    chk({3'h0, abort_out}, 8'h05);
    rd(dmac_pkg::ARM_ADDR, 8'h1a);
    wr(dmac_pkg::ARM_ADDR, 8'h00);
    wr(dmac_pkg::REQ_ADDR, 8'he0);
    rd(dmac_pkg::REQ_ADDR, 8'h00);
    for (int ch = 0; ch < 5; ch++) begin
      en = $urandom_range(1);
      rep = $urandom_range(1);
      channel_irq_enable_in[ch] = en[0];
      repeat_mode_in[ch] = rep[0];
      priority_in[2*ch +: 2] = 2'(ch % 3);
      cpu_mode = 2'h1;
      wr(dmac_pkg::REQ_ADDR, 8'(1 << ch));
      wait_grant(ch, 4);
      chk(8'(n < 0), 8'h01);
      arm_m |= 1 << ch;
      wr(dmac_pkg::ARM_ADDR, 8'(arm_m));
      wait_grant(ch, 6);
      if (ch % 3 == 0) begin
        chk(8'(n < 0), 8'h01);
        rd(dmac_pkg::REQ_ADDR, 8'(1 << ch));
        cpu_mode = 2'h0;
        wait_grant(ch, 4);
      end
      if (ch % 3 == 1) chk(8'(n >= 0 && n <= 2), 8'h01);
      if (ch % 3 == 2) chk({7'h0, st}, 8'h01);
      chk(8'(n >= 0), 8'h01);
      rd(dmac_pkg::REQ_ADDR, 8'h00);
      cpu_mode = 2'h2;
      count_reached_in[ch] = 1'b1;
      @(negedge ref_clk_in);
      count_reached_in[ch] = 1'b0;
      chk({3'h0, irq_req_out}, 8'(en << ch));
      flag_m |= 1 << ch;
      if (rep == 0) arm_m &= ~(1 << ch);
      rd(dmac_pkg::FLAG_ADDR, 8'(flag_m));
      rd(dmac_pkg::ARM_ADDR, 8'(arm_m));
      chk({3'h0, channel_done_flag_out}, 8'(flag_m));
      chk({3'h0, channel_arm_bit_out}, 8'(arm_m));
    end
    cpu_mode = 2'h0;
    trigger_select_in[9:5] = dmac_pkg::TRIGGER_SELECT_PREV;
    // Single mode on channel 0 so the count really disarms it
    repeat_mode_in = '0;
    wr(dmac_pkg::ARM_ADDR, 8'h03);
    count_reached_in[0] = 1'b1;
    @(negedge ref_clk_in);
    count_reached_in[0] = 1'b0;
    wait_grant(1, 6);
    chk(8'(n >= 0), 8'h01);
    chk({3'h0, channel_arm_bit_out}, 8'h02);
    // Peripheral pulse must be ignored with no trigger selected, taken otherwise
    wr(dmac_pkg::ARM_ADDR, 8'h04);
    periph_trigger_in[2] = 1'b1;
    @(negedge ref_clk_in);
    periph_trigger_in[2] = 1'b0;
    wait_grant(2, 4);
    chk(8'(n < 0), 8'h01);
    trigger_select_in[14:10] = 5'h02;
    periph_trigger_in[2] = 1'b1;
    @(negedge ref_clk_in);
    periph_trigger_in[2] = 1'b0;
    wait_grant(2, 4);
    chk(8'(n >= 0), 8'h01);
    for (int k = 0; k < 3; k++) begin
      length_seven_bit_select_in[2] = (k != 1);
      variable_length_mode_in[8:6] = 3'h1;
      transfer_word_size_in[2] = (k == 2);
      len_byte_in = 8'($urandom) | 8'h80;
      len_ch_in = 3'h2;
      len_load_in = 1'b1;
      @(negedge ref_clk_in);
      len_load_in = 1'b0;
      @(negedge ref_clk_in);
      chk(len_rdata_out, (k == 0) ? (len_byte_in & 8'h7f) : len_byte_in);
    end
    wr(dmac_pkg::FLAG_ADDR, 8'h00);
    rd(dmac_pkg::FLAG_ADDR, 8'h00);
    test_done();
  end
endmodule : dmac_ctrl_tb_top
bind dmac_ctrl dmac_ctrl_monitor u_mon (.ref_clk_in, .reset_n_in, .sfr_wr_in, .sfr_rd_in,
  .sfr_addr_in, .sfr_wdata_in, .sfr_rdata_out, .channel_irq_enable_in, .priority_in,
  .repeat_mode_in, .cpu_mem_req_in, .count_reached_in, .channel_arm_bit_out, .grant_out,
  .cpu_stall_out, .irq_req_out, .channel_done_flag_out);
`default_nettype wire
